// ==== rtl/mode_cfg_map.svh ====
// register index, field positions, reset values and timing counts
`ifndef MODE_CFG_MAP_SVH
`define MODE_CFG_MAP_SVH

// configuration register is coprocessor-0 register 3
`define CFG_REG_IDX 5'h03
`define CP0_SEL_W 5

// field positions inside the configuration word
`define CFG_LOCK_BIT 31
`define CFG_SLOW_BUS_BIT 30
`define CFG_FILL_BIT 29
`define CFG_ROUTE_MSB 28
`define CFG_ROUTE_LSB 23
`define CFG_HALT_BIT 22
`define CFG_DIV_BIT 21
`define CFG_SPLIT_BIT 20

// reset values of the software fields
`define CFG_ROUTE_RST 6'h08
`define CFG_LOCK_RST 1'b0
`define CFG_HALT_RST 1'b0
`define CFG_DIV_RST 1'b0
`define CFG_SPLIT_RST 1'b0

// mode vector positions on the interrupt inputs
`define MODE_SNOOP_PIN 5
`define MODE_1X_PIN 4
`define MODE_HALF_PIN 3
`define MODE_QUAD_PIN 2
`define MODE_TRI_PIN 1
`define MODE_ENDIAN_PIN 0

// clock ratios
`define REDUCED_DIV 16
`define INPUT_2X_DIV 2
`define HALF_BUS_DIV 2

// bus turnaround, in bus clock periods
`define TURN_NORMAL 1
`define TURN_SLOW 3

// interrupt pins held off after reset while the synchroniser drains
`define PIN_SETTLE 2

`endif

// ==== rtl/mode_cfg_pkg.sv ====
// types shared by the mode and configuration block
package mode_cfg_pkg;

	typedef enum logic [1:0] {
		EXEC_RUN = 2'b01,
		EXEC_HALTED = 2'b10
	} exec_state_type;

	typedef logic [31:0] cfg_word_type;

endpackage

// ==== rtl/reset_mode_and_config_register.sv ====
// reset mode vector capture and configuration register of the core
`include "mode_cfg_map.svh"

module reset_mode_and_config_register #(
	parameter int IRQ_W = 6,
	parameter int ADDR_W = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [IRQ_W-1:0] irq_in_n,
	input wire logic fp_irq,
	input wire logic [`CP0_SEL_W-1:0] cp0_sel,
	input wire logic cp0_wr,
	input wire logic cp0_rd,
	input wire mode_cfg_pkg::cfg_word_type cp0_wdata,
	input wire logic read_data_done,
	input wire logic bus_start_req,
	input wire logic dma_inval_req,
	input wire logic [ADDR_W-1:0] dma_inval_addr,
	output mode_cfg_pkg::cfg_word_type cp0_rdata,
	output logic snoop_invalidate_on,
	output logic exec_rate_clock_sel,
	output logic half_bus_on,
	output logic quad_refill_default,
	output logic tristate_test_on,
	output logic byte_order_high_first,
	output logic dcache_fill_size,
	output logic equal_cache_split,
	output logic slow_bus_turn,
	output logic exec_ce,
	output logic bus_ce,
	output logic exec_stalled,
	output logic bus_drive_ok,
	output logic [IRQ_W-1:0] cpu_irq,
	output logic inval_strobe,
	output logic [ADDR_W-1:0] inval_addr
);
	import mode_cfg_pkg::*;

	logic [IRQ_W-1:0] irq_meta_reg;
	logic [IRQ_W-1:0] irq_sync_reg;
	logic lock_reg;
	logic halt_reg;
	logic div_reg;
	logic [IRQ_W-1:0] route_reg;
	logic [IRQ_W-1:0] route_next;
	logic [IRQ_W-1:0] pin_irq;
	logic any_irq;
	logic cfg_write;
	cfg_word_type cfg_word;
	exec_state_type state_reg;
	logic [5:0] exec_cnt_reg;
	logic [5:0] exec_period;
	logic bus_phase_reg;
	logic [1:0] turn_cnt_reg;
	logic [1:0] settle_cnt_reg;
	logic pins_live;

	// two-stage synchroniser for the interrupt pins
	always_ff @(posedge clk) begin
		irq_meta_reg <= irq_in_n;
		irq_sync_reg <= irq_meta_reg;
	end

	// mode vector still sits in the synchroniser for two edges after reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			settle_cnt_reg <= 2'(`PIN_SETTLE);
		end else if (settle_cnt_reg != 2'h0) begin
			settle_cnt_reg <= settle_cnt_reg - 2'h1;
		end
	end

	// pins count as interrupts only once the mode vector has drained
	assign pins_live = (settle_cnt_reg == 2'h0);

	// mode vector: follows the pins while reset is low, frozen after
	always_ff @(posedge clk) begin
		if (!rstn) begin
			// pins are active low: low level enables the mode
			snoop_invalidate_on <= ~irq_sync_reg[`MODE_SNOOP_PIN];
			exec_rate_clock_sel <= ~irq_sync_reg[`MODE_1X_PIN];
			half_bus_on <= ~irq_sync_reg[`MODE_HALF_PIN];
			quad_refill_default <= ~irq_sync_reg[`MODE_QUAD_PIN];
			tristate_test_on <= ~irq_sync_reg[`MODE_TRI_PIN];
			byte_order_high_first <= ~irq_sync_reg[`MODE_ENDIAN_PIN];
		end else begin
			// hold until next reset, pins ignored
			snoop_invalidate_on <= snoop_invalidate_on;
			exec_rate_clock_sel <= exec_rate_clock_sel;
			half_bus_on <= half_bus_on;
			quad_refill_default <= quad_refill_default;
			tristate_test_on <= tristate_test_on;
			byte_order_high_first <= byte_order_high_first;
		end
	end

	// write strobe for the configuration register
	assign cfg_write = cp0_wr && (cp0_sel == `CFG_REG_IDX) && !lock_reg;

	// routing keeps its old value unless the new one is one-hot
	always_comb begin
		route_next = route_reg;
		if ($onehot(cp0_wdata[`CFG_ROUTE_MSB:`CFG_ROUTE_LSB])) begin
			route_next = cp0_wdata[`CFG_ROUTE_MSB:`CFG_ROUTE_LSB];
		end
	end

	// lock: once set only reset clears it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lock_reg <= `CFG_LOCK_RST;
		end else if (cfg_write && cp0_wdata[`CFG_LOCK_BIT]) begin
			lock_reg <= 1'b1;
		end
	end

	// software fields; fill size and slow bus turn take mode-dependent reset values
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dcache_fill_size <= ~irq_sync_reg[`MODE_QUAD_PIN];
			slow_bus_turn <= ~irq_sync_reg[`MODE_HALF_PIN];
			route_reg <= `CFG_ROUTE_RST;
			div_reg <= `CFG_DIV_RST;
			equal_cache_split <= `CFG_SPLIT_RST;
		end else if (cfg_write) begin
			dcache_fill_size <= cp0_wdata[`CFG_FILL_BIT];
			slow_bus_turn <= cp0_wdata[`CFG_SLOW_BUS_BIT];
			route_reg <= route_next;
			div_reg <= cp0_wdata[`CFG_DIV_BIT];
			equal_cache_split <= cp0_wdata[`CFG_SPLIT_BIT];
		end
	end

	// interrupt routing: float unit replaces the chosen pin
	generate
		for (genvar i = 0; i < IRQ_W; i++) begin : g_route
			// pin level on the routed input is dropped
			assign pin_irq[i] = route_reg[i] ? fp_irq :
				(~irq_sync_reg[i] && pins_live);
			always_ff @(posedge clk) begin
				if (!rstn) begin
					cpu_irq[i] <= 1'b0;
				end else begin
					cpu_irq[i] <= pin_irq[i];
				end
			end
		end
	endgenerate

	// any routed or pin interrupt wakes a halted core
	assign any_irq = |pin_irq;

	// halt bit: set by software, cleared by any interrupt
	always_ff @(posedge clk) begin
		if (!rstn) begin
			halt_reg <= `CFG_HALT_RST;
		end else if (cfg_write) begin
			halt_reg <= cp0_wdata[`CFG_HALT_BIT];
		end else if (any_irq) begin
			halt_reg <= 1'b0;
		end
	end

	// execution state follows the halt bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= EXEC_RUN;
		end else begin
			unique case (state_reg)
				EXEC_RUN: begin
					if (halt_reg && !any_irq) begin
						state_reg <= EXEC_HALTED;
					end
				end
				EXEC_HALTED: begin
					if (any_irq || !halt_reg) begin
						state_reg <= EXEC_RUN;
					end
				end
			endcase
		end
	end

	// stall flag lags the state by one cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			exec_stalled <= 1'b0;
		end else begin
			exec_stalled <= (state_reg == EXEC_HALTED);
		end
	end

	// execution period in input clocks: 2x input halves, reduced mode /16
	always_comb begin
		exec_period = exec_rate_clock_sel ? 6'h01 : 6'(`INPUT_2X_DIV);
		if (div_reg) begin
			exec_period = 6'(32'(exec_period) * `REDUCED_DIV);
		end
	end

	// execution clock enable divider
	always_ff @(posedge clk) begin
		if (!rstn) begin
			exec_cnt_reg <= 6'h00;
			exec_ce <= 1'b0;
		end else if (exec_cnt_reg >= exec_period - 6'h01) begin
			exec_cnt_reg <= 6'h00;
			exec_ce <= 1'b1;
		end else begin
			exec_cnt_reg <= exec_cnt_reg + 6'h01;
			exec_ce <= 1'b0;
		end
	end

	// bus clock enable: every execution period or every second one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bus_phase_reg <= 1'b0;
			bus_ce <= 1'b0;
		end else if (exec_cnt_reg >= exec_period - 6'h01) begin
			bus_phase_reg <= half_bus_on ? ~bus_phase_reg : 1'b0;
			bus_ce <= !half_bus_on || bus_phase_reg;
		end else begin
			bus_ce <= 1'b0;
		end
	end

	// turnaround gap after memory drove read data
	always_ff @(posedge clk) begin
		if (!rstn) begin
			turn_cnt_reg <= 2'h0;
			bus_drive_ok <= 1'b1;
		end else if (read_data_done) begin
			turn_cnt_reg <= slow_bus_turn ? 2'(`TURN_SLOW) : 2'(`TURN_NORMAL);
			bus_drive_ok <= 1'b0;
		end else if (bus_ce && turn_cnt_reg != 2'h0) begin
			turn_cnt_reg <= turn_cnt_reg - 2'h1;
			bus_drive_ok <= (turn_cnt_reg == 2'h1);
		end else if (bus_start_req && bus_drive_ok) begin
			bus_drive_ok <= 1'b1;
		end
	end

	// snoop invalidation passes only when enabled at reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			inval_strobe <= 1'b0;
			inval_addr <= '0;
		end else begin
			inval_strobe <= dma_inval_req && snoop_invalidate_on;
			if (dma_inval_req && snoop_invalidate_on) begin
				inval_addr <= dma_inval_addr;
			end
		end
	end

	// read image of the register, reserved bits zero
	always_comb begin
		cfg_word = '0;
		cfg_word[`CFG_LOCK_BIT] = lock_reg;
		cfg_word[`CFG_SLOW_BUS_BIT] = slow_bus_turn;
		cfg_word[`CFG_FILL_BIT] = dcache_fill_size;
		cfg_word[`CFG_ROUTE_MSB:`CFG_ROUTE_LSB] = route_reg;
		cfg_word[`CFG_HALT_BIT] = halt_reg;
		cfg_word[`CFG_DIV_BIT] = div_reg;
		cfg_word[`CFG_SPLIT_BIT] = equal_cache_split;
	end

	// registered read port, zero for other selects
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cp0_rdata <= '0;
		end else if (cp0_rd && cp0_sel == `CFG_REG_IDX) begin
			cp0_rdata <= cfg_word;
		end else begin
			cp0_rdata <= '0;
		end
	end

endmodule

// ==== verif/board_mode_drv.sv ====
// board logic driving mode vectors or interrupts on the pins
module board_mode_drv (
	input wire logic rstn,
	input wire logic [5:0] mode_vec,
	input wire logic [5:0] irq_req,
	output logic [5:0] irq_in_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// low pin selects a mode in reset, else carries an interrupt
	assign irq_in_n = !rstn ? ~mode_vec : ~irq_req;
endmodule

// ==== verif/mode_cfg_monitor.sv ====
// assertion checker for the mode and configuration block
module mode_cfg_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cp0_wr,
	input wire logic cp0_rd,
	input wire logic [4:0] cp0_sel,
	input wire mode_cfg_pkg::cfg_word_type cp0_rdata,
	input wire logic read_data_done,
	input wire logic bus_drive_ok,
	input wire logic dma_inval_req,
	input wire logic inval_strobe,
	input wire logic snoop_invalidate_on,
	input wire logic half_bus_on,
	input wire logic exec_stalled
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// read port answers only to register 3
	chk_rd_source: assert property (cp0_rdata != 32'h0 |->
		$past(cp0_rd && cp0_sel == 5'h03)) else $error("stray read data");
	chk_other_sel: assert property (cp0_rd && cp0_sel != 5'h03 |=>
		cp0_rdata == 32'h0) else $error("other register not zero");
	chk_reserved_zero: assert property (cp0_rdata[19:0] == 20'h0)
		else $error("reserved bits set");
	chk_route_onehot: assert property (cp0_rdata != 32'h0 |->
		$onehot(cp0_rdata[28:23])) else $error("route not one-hot");
	// side effects on the bus, cache, mode vector and execution stall
	chk_inval_gate: assert property (inval_strobe |->
		$past(dma_inval_req && snoop_invalidate_on)) else $error("bad inval");
	chk_turn_drop: assert property (read_data_done |=> !bus_drive_ok)
		else $error("bus not held off");
	chk_mode_hold: assert property ($past(rstn) |->
		$stable(snoop_invalidate_on) && $stable(half_bus_on))
		else $error("mode changed");
	chk_stall_cause: assert property ($rose(exec_stalled) |->
		$past(cp0_wr, 2) || $past(cp0_wr, 3)) else $error("stall w/o write");
	cover property (exec_stalled);
	cover property (inval_strobe);
	cover property ($fell(bus_drive_ok));
endmodule

bind reset_mode_and_config_register mode_cfg_monitor mon_inst (.clk(clk),
	.rstn(rstn), .cp0_wr(cp0_wr), .cp0_rd(cp0_rd), .cp0_sel(cp0_sel),
	.cp0_rdata(cp0_rdata), .read_data_done(read_data_done),
	.bus_drive_ok(bus_drive_ok), .dma_inval_req(dma_inval_req),
	.inval_strobe(inval_strobe), .half_bus_on(half_bus_on),
	.snoop_invalidate_on(snoop_invalidate_on), .exec_stalled(exec_stalled));

// ==== verif/reset_mode_and_config_register_tb.sv ====
// testbench for the mode and configuration block
module reset_mode_and_config_register_tb;
	import mode_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, cp0_wr = 0, cp0_rd = 0, fp_irq = 0;
	logic read_data_done = 0, dma_inval_req = 0, bus_start_req = 0;
	logic [4:0] cp0_sel = 5'h03;
	cfg_word_type cp0_wdata = 32'h0, cp0_rdata;
	logic [31:0] dma_inval_addr = 32'hA5A50000, inval_addr;
	logic [5:0] mode_vec = 6'h00, irq_req = 6'h00, irq_in_n, cpu_irq;
	logic snoop_invalidate_on, exec_rate_clock_sel, half_bus_on;
	logic quad_refill_default, tristate_test_on, byte_order_high_first;
	logic dcache_fill_size, equal_cache_split, slow_bus_turn, exec_ce;
	logic bus_ce, exec_stalled, bus_drive_ok, inval_strobe;
	logic [5:0] modes;
	int n_errors = 0, n_checks = 0, cyc = 0, ne, nb;
	assign modes = {snoop_invalidate_on, exec_rate_clock_sel, half_bus_on,
		quad_refill_default, tristate_test_on, byte_order_high_first};
	reset_mode_and_config_register reset_mode_and_config_register_inst (
		.clk, .rstn, .irq_in_n, .fp_irq, .cp0_sel, .cp0_wr, .cp0_rd,
		.cp0_wdata, .read_data_done, .bus_start_req, .dma_inval_req,
		.dma_inval_addr, .cp0_rdata, .snoop_invalidate_on,
		.exec_rate_clock_sel, .half_bus_on, .quad_refill_default,
		.tristate_test_on, .byte_order_high_first, .dcache_fill_size,
		.equal_cache_split, .slow_bus_turn, .exec_ce, .bus_ce,
		.exec_stalled, .bus_drive_ok, .cpu_irq, .inval_strobe, .inval_addr);
	board_mode_drv board_mode_drv_inst (.rstn, .mode_vec, .irq_req,
		.irq_in_n);
	// clock and cycle ceiling
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test;
		end
	end
	task finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [31:0] d);
		tick(1);
		cp0_wr = 1;
		cp0_wdata = d;
		tick(1);
		cp0_wr = 0;
	endtask
	task rd(input logic [31:0] e);
		tick(1);
		cp0_rd = 1;
		tick(1);
		cp0_rd = 0;
		chk(cp0_rdata, e);
	endtask
	// count rate enables over 64 clocks
	task cnt(output int a, output int b);
		a = 0;
		b = 0;
		repeat (64) begin
			tick(1);
			a += exec_ce;
			b += bus_ce;
		end
	endtask
	task inv(input logic e);
		dma_inval_req = 1;
		tick(1);
		chk(inval_strobe, e);
		dma_inval_req = 0;
	endtask
	// main sequence
	initial begin
		tick(3);
		rstn = 1;
		chk(modes, 32'h0);
		rd(32'h04000000);
		cnt(ne, nb);
		chk(ne, 32);
		chk(nb, 32);
		inv(0);
		wr(32'h60900000);
		chk({equal_cache_split, dcache_fill_size}, 32'h3);
		chk(slow_bus_turn, 1'b1);
		rd(32'h60900000);
		wr(32'h61900000);
		rd(32'h60900000);
		cp0_sel = 5'h05;
		rd(32'h0);
		cp0_sel = 5'h03;
		read_data_done = 1;
		tick(1);
		read_data_done = 0;
		tick(3);
		chk(bus_drive_ok, 0);
		tick(8);
		chk(bus_drive_ok, 1);
		irq_req = 6'h01;
		tick(4);
		chk(cpu_irq, 32'h0);
		fp_irq = 1;
		tick(2);
		chk(cpu_irq, 32'h1);
		fp_irq = 0;
		irq_req = 6'h00;
		wr(32'h00C00000);
		tick(3);
		chk(exec_stalled, 1);
		irq_req = 6'h02;
		tick(8);
		chk(exec_stalled, 0);
		irq_req = 6'h00;
		wr(32'h04200000);
		cnt(ne, nb);
		chk(ne, 2);
		wr(32'h84000000);
		wr(32'h00100000);
		rd(32'h84000000);
		mode_vec = 6'h3F;
		rstn = 0;
		tick(4);
		rstn = 1;
		chk(modes, 32'h3F);
		rd(32'h64000000);
		chk(cpu_irq, 32'h0);
		cnt(ne, nb);
		chk(ne, 64);
		chk(nb, 32);
		irq_req = 6'h3F;
		tick(6);
		chk(modes, 32'h3F);
		irq_req = 6'h00;
		inv(1);
		chk(inval_addr, 32'hA5A50000);
		finish_test;
	end
endmodule
